// ### hw/zss_params.svh
`ifndef ZSS_PARAMS_SVH
`define ZSS_PARAMS_SVH
// register byte offsets
`define ZSS_CTRL_OFS      8'h00
`define ZSS_DELAY_OFS     8'h04
`define ZSS_MAP_LO_OFS    8'h08
`define ZSS_MAP_HI_OFS    8'h0C
`define ZSS_STATUS_OFS    8'h10
`define ZSS_IRQ_STAT_OFS  8'h14
`define ZSS_IRQ_MASK_OFS  8'h18
// ctrl fields
`define ZSS_CTRL_VAR_LSB     0
`define ZSS_CTRL_NGRP_LSB    2
`define ZSS_CTRL_NIN_LSB     6
`define ZSS_CTRL_APPLY_BIT   9
`define ZSS_CTRL_FCLR_BIT    10
// limits per variant
`define ZSS_MAX_GRP_SA    4'h6
`define ZSS_MAX_GRP_M12   4'hA
`define ZSS_MAX_GRP_M8    4'h3
// settling delay
`define ZSS_DELAY_MAX_MS  100
`define ZSS_CLK_HZ        10000000
`define ZSS_CYC_PER_MS    (`ZSS_CLK_HZ / 1000)
`define ZSS_DELAY_MAX_CYC (`ZSS_DELAY_MAX_MS * `ZSS_CYC_PER_MS)
// irq bits
`define ZSS_IRQ_SWITCH    0
`define ZSS_IRQ_FAULT     1
`define ZSS_IRQ_REFUSE    2
// reset values
`define ZSS_CTRL_RST      32'h0000_0004
`define ZSS_DELAY_RST     7'h0A
`endif

// ### hw/zss_pkg.sv
package zss_pkg;
  typedef enum logic [1:0] {ZSS_STANDALONE, ZSS_MASTER12, ZSS_MASTER8} zss_variant_e;
  typedef enum {ZSS_ST_IDLE, ZSS_ST_SETTLE, ZSS_ST_FAULT} zss_state_e;
  typedef struct packed {
    logic [1:0]  variant;
    logic [3:0]  n_groups;
    logic [2:0]  n_inputs;
  } zss_cfg_s;
  typedef struct packed {
    logic        awv;
    logic        wv;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic        bvalid;
    logic        arvalid_q;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } zss_bus_s;
endpackage : zss_pkg

// ### hw/zss_selector.sv
`timescale 1ns/100ps
`include "zss_params.svh"
// Operation
// - group count limited to six, ten or three by variant
// - exactly one group active, chosen only by selection inputs
// - each code maps to one group; duplicate mappings refused
// - a new valid settled code switches to its group
// - single group configured means inputs ignored, group fixed
// - fewer than two selection inputs makes configuration refused, unless only one group is configured
// - settling delay up to 100 ms filters short transients
// - invalid code persisting past delay enters fault
// - all three zone enables stay on for any active group, off while fault
// - staged configuration does not affect running configuration
// - with three inputs all-low and all-high codes are invalid
// - change of only one input level forces lockout fault
module zss_selector (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // selection inputs and zone outputs
  input  wire logic [4:0]  area_switch,
  output logic [3:0]       active_group,
  output logic [2:0]       zone_enable,
  output logic             fault,
  output logic             irq
);

  typedef struct packed {
    zss_pkg::zss_bus_s  bus;
    zss_pkg::zss_cfg_s  run_cfg;
    zss_pkg::zss_cfg_s  stg_cfg;
    logic [6:0]         run_delay;
    logic [6:0]         stg_delay;
    logic [49:0]        run_map;
    logic [49:0]        stg_map;
    logic [4:0]         sync1;
    logic [4:0]         sync2;
    logic [4:0]         cand;
    logic [4:0]         last_code;
    logic [19:0]        cnt;
    logic [1:0]         st;
    logic [3:0]         grp;
    logic [2:0]         zones;
    logic               flt;
    logic               refused;
    logic [2:0]         irq_stat;
    logic [2:0]         irq_mask;
    logic               irq_q;
  } zss_state_s;

  zss_state_s r;
  zss_state_s next_r;

  // code match against run map
  logic [3:0] hit_idx;
  logic       hit;
  logic       apply_ok;
  logic [3:0] max_grp;
  logic [4:0] in_mask;
  logic [4:0] diff;
  logic [2:0] ev;
  logic [19:0] delay_cyc;
  logic       dup;

  always_comb begin
    in_mask = 5'h1F >> (3'h5 - r.run_cfg.n_inputs);
    hit = 1'b0;
    hit_idx = 4'h0;
    for (int i = 0; i < 10; i++) begin
      if (!hit && (4'(i) < r.run_cfg.n_groups) && (r.run_map[i*5 +: 5] == (r.sync2 & in_mask))
          && !(r.run_cfg.n_inputs == 3'h3 && (r.sync2[2:0] == 3'h0 || r.sync2[2:0] == 3'h7))) begin
        hit = 1'b1;
        hit_idx = 4'(i);
      end
    end
    case (r.stg_cfg.variant)
      2'h0:    max_grp = `ZSS_MAX_GRP_SA;
      2'h1:    max_grp = `ZSS_MAX_GRP_M12;
      default: max_grp = `ZSS_MAX_GRP_M8;
    endcase
    dup = 1'b0;
    for (int i = 0; i < 10; i++) begin
      for (int j = 0; j < 10; j++) begin
        if (i < j && 4'(j) < r.stg_cfg.n_groups && r.stg_map[i*5 +: 5] == r.stg_map[j*5 +: 5]) begin
          dup = 1'b1;
        end
      end
    end
    apply_ok = (r.stg_cfg.n_groups != 4'h0) && (r.stg_cfg.n_groups <= max_grp) && !dup
               && (r.stg_cfg.n_groups == 4'h1 || r.stg_cfg.n_inputs >= 3'h2)
               && (r.stg_cfg.n_inputs <= 3'h5) && (r.stg_delay <= 7'd100);
    delay_cyc = 20'(r.run_delay * `ZSS_CYC_PER_MS);
    diff = (r.sync2 ^ r.last_code) & in_mask;
  end

  always_comb begin
    next_r = r;
    ev = 3'h0;
    next_r.sync1 = area_switch;
    next_r.sync2 = r.sync1;
    // bus handshake: address and data taken in either order
    if (awvalid && !r.bus.awv) begin
      next_r.bus.awv = 1'b1;
      next_r.bus.awaddr = awaddr;
    end
    if (wvalid && !r.bus.wv) begin
      next_r.bus.wv = 1'b1;
      next_r.bus.wdata = wdata;
    end
    if (r.bus.bvalid && bready) next_r.bus.bvalid = 1'b0;
    if (r.bus.awv && r.bus.wv && !r.bus.bvalid) begin
      next_r.bus.awv = 1'b0;
      next_r.bus.wv = 1'b0;
      next_r.bus.bvalid = 1'b1;
      case (r.bus.awaddr)
        `ZSS_CTRL_OFS: begin
          // staged only: running config untouched until apply
          next_r.stg_cfg.variant  = r.bus.wdata[`ZSS_CTRL_VAR_LSB +: 2];
          next_r.stg_cfg.n_groups = r.bus.wdata[`ZSS_CTRL_NGRP_LSB +: 4];
          next_r.stg_cfg.n_inputs = r.bus.wdata[`ZSS_CTRL_NIN_LSB +: 3];
          if (r.bus.wdata[`ZSS_CTRL_APPLY_BIT]) begin
            if (apply_ok) begin
              next_r.run_cfg = r.stg_cfg;
              next_r.run_map = r.stg_map;
              next_r.run_delay = r.stg_delay;
            end else begin
              next_r.refused = 1'b1;
              ev[`ZSS_IRQ_REFUSE] = 1'b1;
            end
          end
          if (r.bus.wdata[`ZSS_CTRL_FCLR_BIT]) begin
            next_r.flt = 1'b0;
            next_r.st = 2'(zss_pkg::ZSS_ST_IDLE);
            next_r.last_code = r.sync2 & in_mask;
          end
        end
        `ZSS_DELAY_OFS:   next_r.stg_delay = r.bus.wdata[6:0];
        `ZSS_MAP_LO_OFS:  next_r.stg_map[29:0] = r.bus.wdata[29:0];
        `ZSS_MAP_HI_OFS:  next_r.stg_map[49:30] = r.bus.wdata[19:0];
        `ZSS_IRQ_STAT_OFS: next_r.irq_stat = r.irq_stat & ~r.bus.wdata[2:0];
        `ZSS_IRQ_MASK_OFS: next_r.irq_mask = r.bus.wdata[2:0];
        default: ;
      endcase
    end
    // read path
    if (r.bus.rvalid && rready) next_r.bus.rvalid = 1'b0;
    next_r.bus.arvalid_q = 1'b0;
    if (arvalid && !r.bus.rvalid && !r.bus.arvalid_q) begin
      next_r.bus.arvalid_q = 1'b1;
      next_r.bus.rvalid = 1'b1;
      next_r.bus.rresp = 2'h0;
      case (araddr)
        `ZSS_CTRL_OFS:     next_r.bus.rdata = {23'h0, r.stg_cfg.n_inputs, r.stg_cfg.n_groups,
                                               r.stg_cfg.variant};
        `ZSS_DELAY_OFS:    next_r.bus.rdata = {25'h0, r.stg_delay};
        `ZSS_MAP_LO_OFS:   next_r.bus.rdata = {2'h0, r.stg_map[29:0]};
        `ZSS_MAP_HI_OFS:   next_r.bus.rdata = {12'h0, r.stg_map[49:30]};
        `ZSS_STATUS_OFS:   next_r.bus.rdata = {19'h0, r.refused, r.flt, r.st, r.grp, r.sync2};
        `ZSS_IRQ_STAT_OFS: next_r.bus.rdata = {29'h0, r.irq_stat};
        `ZSS_IRQ_MASK_OFS: next_r.bus.rdata = {29'h0, r.irq_mask};
        default: begin
          next_r.bus.rdata = 32'h0;
          next_r.bus.rresp = 2'h2;
        end
      endcase
    end
    // selection state machine
    if (r.run_cfg.n_groups == 4'h1) begin
      next_r.grp = 4'h0;
      next_r.st = 2'(zss_pkg::ZSS_ST_IDLE);
    end else begin
      case (r.st)
        2'(zss_pkg::ZSS_ST_IDLE): begin
          if (diff != 5'h0) begin
            next_r.cand = r.sync2 & in_mask;
            next_r.cnt = 20'h0;
            next_r.st = 2'(zss_pkg::ZSS_ST_SETTLE);
          end
        end
        2'(zss_pkg::ZSS_ST_SETTLE): begin
          if ((r.sync2 & in_mask) != r.cand) begin
            // transient restarts the filter
            next_r.cand = r.sync2 & in_mask;
            next_r.cnt = 20'h0;
          end else if (r.cnt < delay_cyc) begin
            next_r.cnt = r.cnt + 20'h1;
          end else if (!hit || (diff != 5'h0 && $countones(diff) < 2)) begin
            next_r.flt = 1'b1;
            next_r.st = 2'(zss_pkg::ZSS_ST_FAULT);
            ev[`ZSS_IRQ_FAULT] = 1'b1;
          end else if (diff == 5'h0) begin
            // transient came back to the running code: no transition at all
            next_r.st = 2'(zss_pkg::ZSS_ST_IDLE);
          end else begin
            next_r.grp = hit_idx;
            next_r.last_code = r.cand;
            next_r.st = 2'(zss_pkg::ZSS_ST_IDLE);
            ev[`ZSS_IRQ_SWITCH] = 1'b1;
          end
        end
        2'(zss_pkg::ZSS_ST_FAULT): ; // held until explicit clear
        default: next_r.st = 2'(zss_pkg::ZSS_ST_FAULT);
      endcase
    end
    next_r.zones = r.flt ? 3'h0 : 3'h7;
    next_r.irq_stat = next_r.irq_stat | ev; // set beats clear
    next_r.irq_q = |(next_r.irq_stat & next_r.irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.run_cfg.n_groups <= 4'h1;
      r.stg_cfg.n_groups <= 4'h1;
      r.run_delay <= `ZSS_DELAY_RST;
      r.stg_delay <= `ZSS_DELAY_RST;
    end else begin
      r <= next_r;
    end
  end

  assign awready = !r.bus.awv;
  assign wready = !r.bus.wv;
  assign bvalid = r.bus.bvalid;
  assign bresp = 2'h0;
  assign arready = r.bus.arvalid_q;
  assign rvalid = r.bus.rvalid;
  assign rdata = r.bus.rdata;
  assign rresp = r.bus.rresp;
  assign active_group = r.grp;
  assign zone_enable = r.zones;
  assign fault = r.flt;
  assign irq = r.irq_q;

  a_fault_latch: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(r.flt) |=> r.flt) else $error("fault dropped early");
  a_single_change: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.st == 2'(zss_pkg::ZSS_ST_SETTLE) && r.cnt >= delay_cyc && r.cand == (r.sync2 & in_mask)
     && $countones(diff) == 1 && r.run_cfg.n_groups != 4'h1) |=> r.flt)
    else $error("single input change not faulted");
  a_fixed_group: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.run_cfg.n_groups == 4'h1) |=> (r.grp == 4'h0)) else $error("single group moved");
  a_group_range: assert property (@(posedge aclk) disable iff (!aresetn)
    r.grp < r.run_cfg.n_groups || r.run_cfg.n_groups == 4'h0) else $error("group out of range");
  a_filter_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.st == 2'(zss_pkg::ZSS_ST_SETTLE) && r.cnt < delay_cyc) |=> $stable(r.grp))
    else $error("switched before delay");
  a_invalid_fault: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.st == 2'(zss_pkg::ZSS_ST_SETTLE) && r.cnt >= delay_cyc && r.cand == (r.sync2 & in_mask)
     && !hit && r.run_cfg.n_groups != 4'h1) |=> r.flt) else $error("invalid code not faulted");
  a_zone_off: assert property (@(posedge aclk) disable iff (!aresetn)
    r.flt |=> (zone_enable == 3'h0)) else $error("zones on during fault");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(r.irq_stat & r.irq_mask)) else $error("irq missing");
  c_switch: cover property (@(posedge aclk) disable iff (!aresetn) $changed(r.grp));
  c_fault: cover property (@(posedge aclk) disable iff (!aresetn) $rose(r.flt));
  c_refuse: cover property (@(posedge aclk) disable iff (!aresetn) $rose(r.refused));

endmodule : zss_selector

// ### bench/zss_switcher.sv
`timescale 1ns/100ps
module zss_switcher (
  // clock
  input  wire logic       aclk,
  // selection levels towards the scanner
  output logic      [4:0] area_switch
);
  // the scanner under test sits in a chain of one slave unit
  localparam int slave_units = 1;
  initial area_switch = 5'h00;
  // all bits of a new code land on one edge, so no intermediate code is seen
  task automatic move(input logic [4:0] code);
    @(posedge aclk);
    area_switch <= code;
  endtask : move
endmodule : zss_switcher

// ### bench/tb.sv
`timescale 1ns/100ps
`include "zss_params.svh"
module tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, fault, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rr;
  logic [4:0]  area_switch, cur;
  logic [3:0]  active_group;
  logic [2:0]  zone_enable;
  logic [4:0]  codes [3];
  logic [31:0] bad_ctrl [5];
  logic [31:0] bad_map [5];
  int          n_mismatch, total_checks, cyc, k;

  zss_selector dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .area_switch(area_switch), .active_group(active_group), .zone_enable(zone_enable),
    .fault(fault), .irq(irq)
  );
  zss_switcher sw (.aclk(aclk), .area_switch(area_switch));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // the 1 ms settling runs dominate the budget
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_open, w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw_open || w_open) begin
      @(posedge aclk);
      if (aw_open && awready === 1'b1) begin
        aw_open = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_open && wready === 1'b1) begin
        w_open = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bit a_open, r_open;
    a_open = 1'b1;
    r_open = 1'b1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (a_open || r_open) begin
      @(posedge aclk);
      if (a_open && arready === 1'b1) begin
        a_open = 1'b0;
        arvalid <= 1'b0;
      end
      if (r_open && rvalid === 1'b1) begin
        r_open = 1'b0;
        rd = rdata;
        rr = rresp;
        rready <= 1'b0;
      end
    end
    chk(rd & m, e, "read");
    @(posedge aclk);
  endtask : rchk

  task automatic wait_sig(input logic [4:0] e, input logic [4:0] m, input int lim);
    for (int i = 0; i < lim; i++) begin
      if (({active_group, fault} & m) === e) break;
      @(posedge aclk);
    end
    chk({active_group, fault} & m, e, "group_fault");
  endtask : wait_sig

  function automatic logic [3:0] exp_grp(input logic [4:0] c);
    exp_grp = 4'hF;
    for (int g = 0; g < 3; g++)
      if (codes[g] === c) exp_grp = g[3:0];
  endfunction : exp_grp

  initial begin
    void'($urandom(32'h7971));
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    codes = '{5'h03, 5'h05, 5'h06};
    bad_ctrl = '{32'h248, 32'h2DC, 32'h2ED, 32'h2D2, 32'h2CE};
    bad_map = '{32'h18A3, 32'h18A3, 32'h18A3, 32'h18A3, 32'h1863};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(`ZSS_CTRL_OFS, 32'hFFFF_FFFF, `ZSS_CTRL_RST);
    rchk(`ZSS_DELAY_OFS, 32'h7F, 32'h0A);
    rchk(8'h40, 32'h0, 32'h0);
    chk(rr, 2'h2, "unmapped");
    sw.move(5'h05);
    repeat (30) @(posedge aclk);
    chk({active_group, zone_enable, fault}, 8'h0E, "fixed");
    wr(`ZSS_IRQ_MASK_OFS, 32'h7);
    for (k = 0; k < 5; k++) begin
      wr(`ZSS_MAP_LO_OFS, bad_map[k]);
      wr(`ZSS_CTRL_OFS, bad_ctrl[k] & ~32'h200);
      wr(`ZSS_CTRL_OFS, bad_ctrl[k]);
      rchk(`ZSS_IRQ_STAT_OFS, 32'h4, 32'h4);
      chk(irq, 1'b1, "irq");
      wr(`ZSS_IRQ_STAT_OFS, 32'h4);
      rchk(`ZSS_IRQ_STAT_OFS, 32'h4, 32'h0);
      chk({irq, active_group, fault}, 6'h00, "kept");
    end
    wr(`ZSS_MAP_LO_OFS, 32'h18A3);
    wr(`ZSS_CTRL_OFS, 32'h0CE);
    repeat (30) @(posedge aclk);
    chk(active_group, 4'h0, "staged");
    sw.move(codes[0]);
    wr(`ZSS_DELAY_OFS, 32'h0);
    wr(`ZSS_CTRL_OFS, 32'h2CE);
    wait_sig(5'h00, 5'h1F, 40);
    for (k = 0; k < 10; k++) begin
      cur = codes[$urandom_range(2, 0)];
      sw.move(cur);
      wait_sig({exp_grp(cur), 1'b0}, 5'h1F, 40);
    end
    sw.move(codes[0]);
    wait_sig(5'h00, 5'h1F, 40);
    wr(`ZSS_DELAY_OFS, 32'h1);
    wr(`ZSS_CTRL_OFS, 32'h2CE);
    sw.move(codes[1]);
    repeat (100) @(posedge aclk);
    sw.move(codes[0]);
    repeat (12000) @(posedge aclk);
    chk({active_group, fault}, 5'h00, "glitch");
    sw.move(codes[2]);
    repeat (5000) @(posedge aclk);
    chk(active_group, 4'h0, "settling");
    wait_sig(5'h04, 5'h1F, 12000);
    wr(`ZSS_DELAY_OFS, 32'h0);
    wr(`ZSS_CTRL_OFS, 32'h2CE);
    sw.move(5'h04);
    wait_sig(5'h01, 5'h01, 40);
    @(posedge aclk);
    chk({zone_enable, irq}, 4'h1, "fault_out");
    wr(`ZSS_IRQ_MASK_OFS, 32'h0);
    rchk(`ZSS_IRQ_STAT_OFS, 32'h2, 32'h2);
    chk(irq, 1'b0, "masked");
    sw.move(codes[2]);
    repeat (30) @(posedge aclk);
    chk(fault, 1'b1, "latched");
    wr(`ZSS_IRQ_MASK_OFS, 32'h7);
    wr(`ZSS_IRQ_STAT_OFS, 32'h3);
    wr(`ZSS_CTRL_OFS, 32'h4CE);
    wait_sig(5'h04, 5'h1F, 40);
    chk(irq, 1'b0, "irq_clr");
    sw.move(5'h00);
    wait_sig(5'h01, 5'h01, 40);
    sw.move(codes[2]);
    wr(`ZSS_CTRL_OFS, 32'h4CE);
    wait_sig(5'h04, 5'h1F, 40);
    tally_and_finish;
  end
endmodule : tb
